/* File: testbench/ffil_frame_src.sv */
`timescale 1ns/1ps

// ==========================================================
// Protocol engine stand-in: one-cycle frame pulses on request
module ffil_frame_src (
    input wire hclk, // Controller clock
    input wire send, // Bench asks for a frame
    input wire [15:0] id, // Message ID to send
    input wire [10:0] slot, // Slot ID to send
    input wire chan, // Channel to send on
    output reg frame_valid = 1'b0, // Frame pulse
    output reg [15:0] frame_msgid = 16'h0000, // Message ID
    output reg [10:0] frame_slotid = 11'h000, // Slot ID
    output reg frame_chan = 1'b0 // Channel
);
    // Fields are only meaningful with the pulse; otherwise they toggle
    always @(posedge hclk) begin
        frame_valid <= send;
        frame_msgid <= send ? id : ~frame_msgid;
        frame_slotid <= send ? slot : ~frame_slotid;
        frame_chan <= send ? chan : ~frame_chan;
    end
endmodule

/* File: testbench/ffil_rx_fifo_filter_bench.sv */
`timescale 1ns/1ps
`include "ffil_consts.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    err_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end end

module ffil_rx_fifo_filter_bench;
    typedef struct packed {
        logic [1:0] ch;
        logic [15:0] mv;
        logic [15:0] mm;
        logic [10:0] rv;
        logic [10:0] rm;
        logic [15:0] id;
        logic [10:0] sl;
        logic fc;
        logic ex;
    } ffil_row_t;
    reg hclk = 0;
    reg hresetn = 0;
    reg hsel = 0;
    reg hwrite = 0;
    reg config_state = 1; // Host writes in configuration
    reg [31:0] haddr = 0;
    reg [31:0] hwdata = 0;
    reg [1:0] htrans = 0;
    reg [2:0] hsize = `FFIL_HSIZE_WORD;
    wire [31:0] hrdata;
    wire hreadyout, hresp, fifo_store, fifo_drop, frame_valid, frame_chan;
    wire [15:0] frame_msgid;
    wire [10:0] frame_slotid;
    reg send = 0;
    reg s_chan = 0;
    reg [15:0] s_id = 0;
    reg [10:0] s_slot = 0;
    reg rdy_s = 0;
    reg [31:0] rd_s = 0;
    reg [31:0] r;
    integer err_count = 0;
    integer n_tests = 0;
    integer i;
    reg [9:0] idx [0:4];
    reg [31:0] full [0:4];
    ffil_row_t rows [0:9];

    // ==========================================================
    // Clock, bus sampling, design and frame source
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        rdy_s <= hreadyout;
        rd_s <= hrdata;
    end
    ffil_rx_fifo_filter uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .config_state(config_state),
        .frame_valid(frame_valid), .frame_msgid(frame_msgid),
        .frame_slotid(frame_slotid), .frame_chan(frame_chan),
        .fifo_store(fifo_store), .fifo_drop(fifo_drop));
    ffil_frame_src src (.hclk(hclk), .send(send), .id(s_id), .slot(s_slot),
        .chan(s_chan), .frame_valid(frame_valid), .frame_msgid(frame_msgid),
        .frame_slotid(frame_slotid), .frame_chan(frame_chan));

    // ==========================================================
    // Tasks
    task report_and_stop;
        begin
            $display("tests %0d errors %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task wait_rdy;
        integer k;
        begin
            k = 0;
            do begin
                @(posedge hclk);
                #1;
                k++;
            end while (rdy_s !== 1'b1 && k < 20);
            if (rdy_s !== 1'b1) begin
                err_count++;
                $display("[FAIL] %0t bus wait ran out", $time);
                report_and_stop;
            end
        end
    endtask

    // One single word transfer; read data lands in r
    task ahb(input w, input [9:0] ix, input [31:0] d);
        begin
            hsel <= 1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {20'h0, ix, 2'h0};
            wait_rdy;
            htrans <= 2'h0;
            hsel <= 0;
            hwdata <= d;
            wait_rdy;
            r = rd_s;
        end
    endtask

    task frame(input ffil_row_t t);
        begin
            ahb(1, idx[0], {30'h0, t.ch});
            ahb(1, idx[1], {16'h0, t.mv});
            ahb(1, idx[2], {16'h0, t.mm});
            ahb(1, idx[3], {21'h0, t.rv});
            ahb(1, idx[4], {21'h0, t.rm});
            send <= 1;
            s_id <= t.id;
            s_slot <= t.sl;
            s_chan <= t.fc;
            @(posedge hclk);
            #1;
            send <= 0;
            @(posedge hclk);
            #1;
            `CHK({fifo_store, fifo_drop}, {t.ex, ~t.ex})
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        idx = '{`FFIL_IDX_CHAN, `FFIL_IDX_MVAL, `FFIL_IDX_MMASK,
            `FFIL_IDX_RVAL, `FFIL_IDX_RMASK};
        full = '{32'h3, 32'hffff, 32'hffff, 32'h7ff, 32'h7ff};
        rows = '{
        '{2'h3, 16'h1234, 16'hffff, 11'h0, 11'h7ff, 16'h1234, 11'h5, 0, 1},
        '{2'h3, 16'h1234, 16'hffff, 11'h0, 11'h7ff, 16'h1235, 11'h5, 0, 0},
        '{2'h3, 16'h1234, 16'hfff0, 11'h0, 11'h7ff, 16'h123b, 11'h5, 1, 1},
        '{2'h3, 16'h1234, 16'hffff, 11'h5, 11'h7ff, 16'h1234, 11'h5, 0, 0},
        '{2'h3, 16'h1234, 16'hffff, 11'h0, 11'h001, 16'h1234, 11'h2, 1, 0},
        '{2'h3, 16'h1234, 16'hffff, 11'h0, 11'h001, 16'h1234, 11'h3, 1, 1},
        '{2'h1, 16'h1234, 16'h0000, 11'h0, 11'h7ff, 16'h0000, 11'h5, 1, 0},
        '{2'h2, 16'h1234, 16'h0000, 11'h0, 11'h7ff, 16'h0000, 11'h5, 1, 1},
        '{2'h0, 16'h1234, 16'h0000, 11'h0, 11'h7ff, 16'h0000, 11'h5, 0, 0},
        '{2'h1, 16'h1234, 16'h0000, 11'h0, 11'h7ff, 16'h0000, 11'h5, 0, 1}};
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        #1;
        for (i = 0; i < 10; i++) begin
            frame(rows[i]);
        end
        // All-ones writes; reserved bits read back as zero
        for (i = 0; i < 5; i++) begin
            ahb(1, idx[i], 32'hffffffff);
            ahb(0, idx[i], 32'h0);
            `CHK(r, full[i])
        end
        // Back-to-back frames: first passes, second misses its ID
        send <= 1;
        s_id <= 16'hffff;
        s_slot <= 11'h0;
        @(posedge hclk);
        #1;
        s_id <= 16'hfffe;
        @(posedge hclk);
        #1;
        send <= 0;
        `CHK({fifo_store, fifo_drop}, 2'b10)
        @(posedge hclk);
        #1;
        `CHK({fifo_store, fifo_drop}, 2'b01)
        // Write outside configuration leaves the value alone
        config_state <= 0;
        ahb(1, idx[1], 32'h5a5a);
        ahb(0, idx[1], 32'h0);
        `CHK(r, 32'hffff)
        // Status after the refusal, then clear the flag
        ahb(0, `FFIL_IDX_STAT, 32'h0);
        `CHK(r, 32'h22)
        ahb(1, `FFIL_IDX_STAT, 32'h2);
        ahb(0, `FFIL_IDX_STAT, 32'h0);
        `CHK(r, 32'h20)
        // Six stored, six dropped; a write clears both
        ahb(0, `FFIL_IDX_CNT, 32'h0);
        `CHK(r, 32'h606)
        ahb(1, `FFIL_IDX_CNT, 32'h0);
        ahb(0, `FFIL_IDX_CNT, 32'h0);
        `CHK(r, 32'h0)
        config_state <= 1;
        // Byte writes are ignored
        hsize <= 3'h0;
        ahb(1, idx[1], 32'h0);
        hsize <= `FFIL_HSIZE_WORD;
        ahb(0, idx[1], 32'h0);
        `CHK(r, 32'hffff)
        ahb(0, 10'h100, 32'h0);
        `CHK(r, 32'h0)
        // Reset in mid-run clears every filter register
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        #1;
        hresetn <= 1;
        @(posedge hclk);
        #1;
        for (i = 0; i < 5; i++) begin
            ahb(0, idx[i], 32'h0);
            `CHK(r, 32'h0)
        end
        report_and_stop;
    end
endmodule

/* File: testbench/ffil_rx_fifo_filter_properties.sv */
`timescale 1ns/1ps
`include "ffil_consts.vh"

module ffil_rx_fifo_filter_props (
    input wire hclk, // Clock
    input wire hresetn, // Reset, active low
    input wire hsel, // Select
    input wire [31:0] haddr, // Address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write
    input wire [2:0] hsize, // Size
    input wire hready, // Bus ready
    input wire [31:0] hwdata, // Write data
    input wire [31:0] hrdata, // Read data
    input wire hreadyout, // Slave ready
    input wire hresp, // Response
    input wire config_state, // Configuration state
    input wire frame_valid, // Frame pulse
    input wire [15:0] frame_msgid, // Message ID
    input wire [10:0] frame_slotid, // Slot ID
    input wire frame_chan, // Channel
    input wire fifo_store, // Store pulse
    input wire fifo_drop // Drop pulse
);
    // ==========================================================
    // Shadow filter registers, written only in configuration
    reg [1:0] sh_ch;
    reg [15:0] sh_mv;
    reg [15:0] sh_mm;
    reg [10:0] sh_rv;
    reg [10:0] sh_rm;
    reg wr_p;
    reg rd_p;
    reg [9:0] idx_q;
    reg [31:0] rd_exp;
    wire take = hsel && hready && htrans[1] && hsize == `FFIL_HSIZE_WORD
        && haddr[31:12] == `FFIL_ADDR_TOP_ZERO && haddr[1:0] == 2'h0;
    wire chan_ok = frame_chan ? sh_ch[1] : sh_ch[0];
    wire msg_ok = ((frame_msgid ^ sh_mv) & sh_mm) == 16'h0000;
    wire rej = ((frame_slotid ^ sh_rv) & sh_rm) == 11'h000;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_ch <= 2'h0;
            sh_mv <= 16'h0000;
            sh_mm <= 16'h0000;
            sh_rv <= 11'h000;
            sh_rm <= 11'h000;
            wr_p <= 1'b0;
            rd_p <= 1'b0;
            idx_q <= 10'h000;
        end else begin
            wr_p <= take && hwrite;
            rd_p <= take && !hwrite;
            if (take) idx_q <= haddr[11:2];
            if (wr_p && config_state) begin
                case (idx_q)
                    `FFIL_IDX_CHAN: sh_ch <= hwdata[1:0];
                    `FFIL_IDX_MVAL: sh_mv <= hwdata[15:0];
                    `FFIL_IDX_MMASK: sh_mm <= hwdata[15:0];
                    `FFIL_IDX_RVAL: sh_rv <= hwdata[10:0];
                    `FFIL_IDX_RMASK: sh_rm <= hwdata[10:0];
                    default: ;
                endcase
            end
        end
    end

    // Expected read data; status and counters are not modelled
    always @* begin
        case (idx_q)
            `FFIL_IDX_CHAN: rd_exp = {30'h0, sh_ch};
            `FFIL_IDX_MVAL: rd_exp = {16'h0, sh_mv};
            `FFIL_IDX_MMASK: rd_exp = {16'h0, sh_mm};
            `FFIL_IDX_RVAL: rd_exp = {21'h0, sh_rv};
            `FFIL_IDX_RMASK: rd_exp = {21'h0, sh_rm};
            `FFIL_IDX_STAT, `FFIL_IDX_CNT: rd_exp = hrdata;
            default: rd_exp = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    one_answer_a: assert property (
        frame_valid |=> fifo_store != fifo_drop)
        else $error("frame did not get exactly one decision");
    quiet_idle_a: assert property (
        !frame_valid |=> !fifo_store && !fifo_drop)
        else $error("decision without a frame");
    pass_store_a: assert property (
        frame_valid && chan_ok && msg_ok && !rej |=> fifo_store)
        else $error("passing frame not stored");
    chan_block_a: assert property (
        frame_valid && !chan_ok |=> fifo_drop)
        else $error("unselected channel frame not dropped");
    msgid_block_a: assert property (
        frame_valid && !msg_ok |=> fifo_drop)
        else $error("message ID mismatch not dropped");
    reject_hit_a: assert property (
        frame_valid && rej |=> fifo_drop)
        else $error("rejected slot not dropped");
    read_back_a: assert property (
        rd_p |-> hrdata == rd_exp)
        else $error("register read back differs");
    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("bus not ready or not okay");

    cover property (frame_valid ##1 fifo_store);
    cover property (frame_valid && rej);
    cover property (wr_p && !config_state);
endmodule

bind ffil_rx_fifo_filter ffil_rx_fifo_filter_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .config_state(config_state),
    .frame_valid(frame_valid), .frame_msgid(frame_msgid),
    .frame_slotid(frame_slotid), .frame_chan(frame_chan),
    .fifo_store(fifo_store), .fifo_drop(fifo_drop)
);

/* File: verilog/ffil_ahb_front.v */
`timescale 1ns/1ps
`include "ffil_consts.vh"

// ==========================================================
// AHB-Lite address phase decode and write data phase tracking
module ffil_ahb_front (
    input wire hclk,         // Bus clock
    input wire hresetn,      // Async reset, active low
    input wire hsel,         // Slave select
    input wire [31:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite,       // Write when high
    input wire [2:0] hsize,  // Transfer size
    input wire hready,       // Bus ready
    output wire rd_req,      // Read address phase taken
    output wire [9:0] rd_idx, // Register index of read
    output wire wr_req,      // Write data phase now
    output wire [9:0] wr_idx // Register index of write
);
    reg dp_wr;
    reg [9:0] dp_idx;
    wire take;
    wire addr_ok;

    // Word aligned, in range, whole-word transfers only
    assign addr_ok = (haddr[`FFIL_ADDR_TOP_HI:`FFIL_ADDR_TOP_LO] ==
                      `FFIL_ADDR_TOP_ZERO) &&
                     (haddr[1:0] == `FFIL_ADDR_LANE_ZERO) &&
                     (hsize == `FFIL_HSIZE_WORD);
    assign take = hsel & hready & htrans[1] & addr_ok;
    assign rd_req = take & ~hwrite;
    assign rd_idx = haddr[`FFIL_ADDR_IDX_HI:`FFIL_ADDR_IDX_LO];
    assign wr_req = dp_wr;
    assign wr_idx = dp_idx;

    // Remember a write until its data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'h0;
            dp_idx <= 10'h000;
        end else if (hready) begin
            dp_wr <= take & hwrite;
            dp_idx <= haddr[`FFIL_ADDR_IDX_HI:`FFIL_ADDR_IDX_LO];
        end
    end
endmodule

/* File: verilog/ffil_consts.vh */
`ifndef FFIL_CONSTS_VH
`define FFIL_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define FFIL_IDX_CHAN 10'h01a
`define FFIL_IDX_MVAL 10'h01c
`define FFIL_IDX_MMASK 10'h01e
`define FFIL_IDX_RVAL 10'h020
`define FFIL_IDX_RMASK 10'h022
`define FFIL_IDX_STAT 10'h024
`define FFIL_IDX_CNT 10'h026

// ==========================================================
// Address layout
`define FFIL_ADDR_TOP_HI 31
`define FFIL_ADDR_TOP_LO 12
`define FFIL_ADDR_IDX_HI 11
`define FFIL_ADDR_IDX_LO 2
`define FFIL_ADDR_TOP_ZERO 20'h00000
`define FFIL_ADDR_LANE_ZERO 2'h0

// ==========================================================
// Field widths and positions
`define FFIL_MSGID_W 16
`define FFIL_SLOT_W 11
`define FFIL_CNT_W 8
`define FFIL_CHAN_A_BIT 0
`define FFIL_CHAN_B_BIT 1
`define FFIL_CNT_DROP_LO 8
`define FFIL_ST_CONFIG 0
`define FFIL_ST_REFUSED 1
`define FFIL_ST_STORED 2
`define FFIL_ST_REJ_ID 3
`define FFIL_ST_NO_CHAN 4
`define FFIL_ST_NO_MSGID 5

// ==========================================================
// Reset values and constants
`define FFIL_RST_16 16'h0000
`define FFIL_RST_11 11'h000
`define FFIL_RST_2 2'h0
`define FFIL_RST_CNT 8'h00
`define FFIL_CNT_ONE 8'h01
`define FFIL_CNT_MAX 8'hff
`define FFIL_ZERO_32 32'h00000000
`define FFIL_HSIZE_WORD 3'h2
`define FFIL_HRESP_OKAY 1'h0
`define FFIL_CHAN_B 1'h1

`endif

/* File: verilog/ffil_mask_match.v */
`timescale 1ns/1ps

// ==========================================================
// Masked compare: true when every selected bit agrees
module ffil_mask_match #(
    parameter W = 16
) (
    input wire [W-1:0] value, // Stored pattern
    input wire [W-1:0] mask,  // One selects a bit
    input wire [W-1:0] field, // Field from the frame
    output wire match         // All selected bits equal
);
    wire [W-1:0] bit_ok;
    genvar i;

    // A cleared mask bit always agrees
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            assign bit_ok[i] = ~mask[i] | (value[i] == field[i]);
        end
    endgenerate

    assign match = &bit_ok;
endmodule

/* File: verilog/ffil_rx_fifo_filter.v */
// How it works
// [RULE_01] Accept only when masked message ID matches
// [RULE_02] Mask zero makes message ID bit irrelevant
// [RULE_03] Mask one makes message ID bit compared
// [RULE_04] Host changes filters only in configuration
// [RULE_05] Channel bits choose A, B, both, none
// [RULE_06] Channel A bit 0, B bit 1
// [RULE_07] Eleven-bit frame ID rejection value compared
// [RULE_08] Rejection mask zero excludes slot ID bit
// [RULE_09] Rejection mask one includes slot ID bit
// [RULE_10] Hard reset clears all filter registers
// [RULE_11] Store only passing, non-rejected valid frames
// [RULE_12] Writes outside configuration are ignored; the code still acts on status and counter writes
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ffil_consts.vh"

module ffil_rx_fifo_filter (
    input wire hclk,           // Controller clock, 40 MHz
    input wire hresetn,        // Hard reset, async, active low
    input wire hsel,           // AHB slave select
    input wire [31:0] haddr,   // AHB byte address
    input wire [1:0] htrans,   // AHB transfer type
    input wire hwrite,         // AHB write
    input wire [2:0] hsize,    // AHB size
    input wire hready,         // AHB bus ready
    input wire [31:0] hwdata,  // AHB write data
    output reg [31:0] hrdata,  // AHB read data
    output reg hreadyout,      // AHB slave ready
    output reg hresp,          // AHB response
    input wire config_state,   // Controller in configuration
    input wire frame_valid,    // Valid received frame, pulse
    input wire [15:0] frame_msgid, // Message ID of frame
    input wire [10:0] frame_slotid, // Slot ID at reception
    input wire frame_chan,     // 0 channel A, 1 channel B
    output reg fifo_store,     // Store frame in FIFO, pulse
    output reg fifo_drop       // Frame kept out, pulse
);

    // ==========================================================
    // Filter registers
    reg [1:0] chan_sel;
    reg [15:0] msgid_accept_value;
    reg [15:0] msgid_accept_mask;
    reg [10:0] frameid_reject_value;
    reg [10:0] frameid_reject_mask;

    // Next values
    reg [1:0] next_chan_sel;
    reg [15:0] next_msgid_accept_value;
    reg [15:0] next_msgid_accept_mask;
    reg [10:0] next_frameid_reject_value;
    reg [10:0] next_frameid_reject_mask;

    // ==========================================================
    // Status and counters
    // Sticky flag, last cause, saturating counts
    reg wr_refused;
    reg last_stored;
    reg last_rej_id;
    reg last_no_chan;
    reg last_no_msgid;
    reg [7:0] acc_cnt;
    reg [7:0] drop_cnt;

    // Next values and read word
    reg next_wr_refused;
    reg [7:0] next_acc_cnt;
    reg [7:0] next_drop_cnt;
    reg [31:0] rd_word;

    // ==========================================================
    // Bus front end
    wire rd_req;
    wire [9:0] rd_idx;
    wire wr_req;
    wire [9:0] wr_idx;

    ffil_ahb_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .rd_req(rd_req),
        .rd_idx(rd_idx),
        .wr_req(wr_req),
        .wr_idx(wr_idx)
    );

    // ==========================================================
    // Write decode helpers
    // Any of the five filter words
    function is_filter_idx;
        input [9:0] idx;
        begin
            is_filter_idx = (idx == `FFIL_IDX_CHAN) ||
                            (idx == `FFIL_IDX_MVAL) ||
                            (idx == `FFIL_IDX_MMASK) ||
                            (idx == `FFIL_IDX_RVAL) ||
                            (idx == `FFIL_IDX_RMASK);
        end
    endfunction

    // Request aimed at one index
    function wr_hit;
        input req;
        input [9:0] idx;
        input [9:0] target;
        begin
            wr_hit = req && (idx == target);
        end
    endfunction

    // Filter writes land only in configuration state
    wire cfg_wr;
    wire refused_wr;
    assign cfg_wr = wr_req & config_state; // see [RULE_12]

    // A refused filter write sets the flag
    assign refused_wr = wr_req & ~config_state & is_filter_idx(wr_idx);

    // ==========================================================
    // Next filter values
    // Refused writes change no filter value
    always @* begin
        next_chan_sel = chan_sel;
        next_msgid_accept_value = msgid_accept_value;
        next_msgid_accept_mask = msgid_accept_mask;
        next_frameid_reject_value = frameid_reject_value;
        next_frameid_reject_mask = frameid_reject_mask;

        // Only bits 1:0 of the channel word are kept
        if (wr_hit(cfg_wr, wr_idx, `FFIL_IDX_CHAN)) begin
            next_chan_sel = hwdata[1:0]; // see [RULE_06]
        end

        // Message ID filter
        if (wr_hit(cfg_wr, wr_idx, `FFIL_IDX_MVAL)) begin
            next_msgid_accept_value = hwdata[15:0];
        end
        if (wr_hit(cfg_wr, wr_idx, `FFIL_IDX_MMASK)) begin
            next_msgid_accept_mask = hwdata[15:0];
        end

        // Slot ID filter
        if (wr_hit(cfg_wr, wr_idx, `FFIL_IDX_RVAL)) begin
            next_frameid_reject_value = hwdata[10:0]; // see [RULE_07]
        end
        if (wr_hit(cfg_wr, wr_idx, `FFIL_IDX_RMASK)) begin
            next_frameid_reject_mask = hwdata[10:0]; // see [RULE_09]
        end
    end

    // Filter registers, cleared by hard reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_sel <= `FFIL_RST_2; // see [RULE_10]
            msgid_accept_value <= `FFIL_RST_16;
            msgid_accept_mask <= `FFIL_RST_16;
            frameid_reject_value <= `FFIL_RST_11;
            frameid_reject_mask <= `FFIL_RST_11;
        end else begin
            chan_sel <= next_chan_sel;
            msgid_accept_value <= next_msgid_accept_value;
            msgid_accept_mask <= next_msgid_accept_mask;
            frameid_reject_value <= next_frameid_reject_value;
            frameid_reject_mask <= next_frameid_reject_mask;
        end
    end

    // ==========================================================
    // Frame decision
    wire msgid_ok;
    wire id_reject;
    wire chan_ok;
    wire frame_pass;

    // Message ID acceptance, mask one compares a bit
    ffil_mask_match #(
        .W(`FFIL_MSGID_W)
    ) u_msgid (
        .value(msgid_accept_value),
        .mask(msgid_accept_mask),
        .field(frame_msgid),
        .match(msgid_ok)
    ); // see [RULE_01] see [RULE_02] see [RULE_03]

    // Slot ID rejection, mask zero drops a bit out
    // After reset the mask is zero: every slot matches
    // and every frame is dropped until software sets it
    ffil_mask_match #(
        .W(`FFIL_SLOT_W)
    ) u_reject (
        .value(frameid_reject_value),
        .mask(frameid_reject_mask),
        .field(frame_slotid),
        .match(id_reject)
    ); // see [RULE_07] see [RULE_08] see [RULE_09]

    // Channel gate; both bits clear ignores every frame
    assign chan_ok = (frame_chan == `FFIL_CHAN_B) ?
                     chan_sel[`FFIL_CHAN_B_BIT] :
                     chan_sel[`FFIL_CHAN_A_BIT]; // see [RULE_05]
    assign frame_pass = chan_ok & msgid_ok & ~id_reject; // see [RULE_11]

    // Store or drop pulse one cycle after the frame
    // Exactly one of the two, never both
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_store <= 1'h0;
            fifo_drop <= 1'h0;
        end else begin
            fifo_store <= frame_valid & frame_pass; // see [RULE_11]
            fifo_drop <= frame_valid & ~frame_pass;
        end
    end

    // Cause of the last decision
    // Held until the next frame arrives
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_stored <= 1'h0;
            last_rej_id <= 1'h0;
            last_no_chan <= 1'h0;
            last_no_msgid <= 1'h0;
        end else if (frame_valid) begin
            last_stored <= frame_pass;
            last_rej_id <= id_reject;
            last_no_chan <= ~chan_ok;
            last_no_msgid <= ~msgid_ok;
        end
    end

    // ==========================================================
    // Refused-write flag and frame counters
    always @* begin
        next_wr_refused = wr_refused;
        next_acc_cnt = acc_cnt;
        next_drop_cnt = drop_cnt;

        // Writing one to the flag clears it; a new refusal wins
        if (wr_hit(wr_req, wr_idx, `FFIL_IDX_STAT) &&
            hwdata[`FFIL_ST_REFUSED]) begin
            next_wr_refused = 1'h0;
        end
        if (refused_wr) begin
            next_wr_refused = 1'h1; // see [RULE_04]
        end
        // Any write clears counters; a frame in that cycle counts
        if (wr_hit(wr_req, wr_idx, `FFIL_IDX_CNT)) begin
            next_acc_cnt = `FFIL_RST_CNT;
            next_drop_cnt = `FFIL_RST_CNT;
        end

        // Saturating frame counters
        if (frame_valid && frame_pass &&
            (next_acc_cnt != `FFIL_CNT_MAX)) begin
            next_acc_cnt = next_acc_cnt + `FFIL_CNT_ONE;
        end
        if (frame_valid && !frame_pass &&
            (next_drop_cnt != `FFIL_CNT_MAX)) begin
            next_drop_cnt = next_drop_cnt + `FFIL_CNT_ONE;
        end
    end

    // Flag and counter registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_refused <= 1'h0;
            acc_cnt <= `FFIL_RST_CNT;
            drop_cnt <= `FFIL_RST_CNT;
        end else begin
            wr_refused <= next_wr_refused;
            acc_cnt <= next_acc_cnt;
            drop_cnt <= next_drop_cnt;
        end
    end

    // ==========================================================
    // Read multiplexer
    // Uses next values so a read right after a write sees it
    always @* begin
        rd_word = `FFIL_ZERO_32;
        case (rd_idx)
            `FFIL_IDX_CHAN: begin
                rd_word[1:0] = next_chan_sel; // see [RULE_06]
            end
            `FFIL_IDX_MVAL: begin
                rd_word[15:0] = next_msgid_accept_value;
            end
            `FFIL_IDX_MMASK: begin
                rd_word[15:0] = next_msgid_accept_mask;
            end
            `FFIL_IDX_RVAL: begin
                rd_word[10:0] = next_frameid_reject_value;
            end
            `FFIL_IDX_RMASK: begin
                rd_word[10:0] = next_frameid_reject_mask;
            end
            `FFIL_IDX_STAT: begin
                // Bit 0 follows the pin live
                rd_word[`FFIL_ST_CONFIG] = config_state;
                rd_word[`FFIL_ST_REFUSED] = next_wr_refused;
                rd_word[`FFIL_ST_STORED] = last_stored;
                rd_word[`FFIL_ST_REJ_ID] = last_rej_id;
                rd_word[`FFIL_ST_NO_CHAN] = last_no_chan;
                rd_word[`FFIL_ST_NO_MSGID] = last_no_msgid;
            end
            `FFIL_IDX_CNT: begin
                // Stored in bits 7:0, dropped in bits 15:8
                rd_word[`FFIL_CNT_W-1:0] = next_acc_cnt;
                rd_word[`FFIL_CNT_DROP_LO+`FFIL_CNT_W-1:
                        `FFIL_CNT_DROP_LO] = next_drop_cnt;
            end
            default: begin
                rd_word = `FFIL_ZERO_32;
            end
        endcase
    end

    // ==========================================================
    // Bus answer: zero wait states, always OKAY
    // Ready stays high, even in reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `FFIL_ZERO_32;
            hreadyout <= 1'h1;
            hresp <= `FFIL_HRESP_OKAY;
        end else begin
            hreadyout <= 1'h1;
            hresp <= `FFIL_HRESP_OKAY;
            // Read data stands until the next read, or a
            // ready edge without a read clears it
            if (rd_req) begin
                hrdata <= rd_word;
            end else if (hready) begin
                hrdata <= `FFIL_ZERO_32;
            end
        end
    end

endmodule
